// file: bench/adc_config_event_trigger_tb_top.sv
// Self-checking bench for the converter control slice over its register bus.
`timescale 1ns/10ps
`include "adc_cfg_defs.svh"
module adc_config_event_trigger_tb_top;
	import adc_cfg_pkg::*;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, compare_mode, err;
	logic compare_met, vector_ack, bandgap_enable, thermal_sensor_enable, flag;
	logic adc_clk, sampling, converting, conv_done, flush_pulse;
	logic [7:0] paddr, event_in;
	logic [31:0] pwdata, prdata, rdata;
	logic [15:0] result_value;
	logic [11:0] trim_value;
	ref_sel_t reference_select;
	int failures = 0;
	int checked = 0;
	int cycles = 0;
	int n;
	time t0;

	// Free-running bus clock at 250 MHz.
	initial begin
		pclk = 1'b0;
		forever #2 pclk = ~pclk;
	end

	adc_config_event_trigger dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .event_in(event_in),
		.compare_mode(compare_mode), .compare_met(compare_met), .vector_ack(vector_ack),
		.result_value(result_value), .reference_select(reference_select),
		.bandgap_enable(bandgap_enable), .thermal_sensor_enable(thermal_sensor_enable),
		.trim_value(trim_value), .conversion_done_flag(flag), .adc_clk(adc_clk),
		.sampling(sampling), .converting(converting), .conv_done(conv_done),
		.flush_pulse(flush_pulse));
	event_source partner (.pclk(pclk), .event_in(event_in), .compare_met(compare_met),
		.vector_ack(vector_ack));

	// Case equality so an unknown never counts as a match.
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			failures++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	// One bus transfer; the request stands until pready is seen high at a rising edge.
	task automatic apb(input logic wr, input logic [5:0] idx, input logic [7:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= {idx, 2'b00};
		pwdata <= {24'h00_0000, d};
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rdata = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rd(input logic [5:0] idx, input logic [7:0] exp);
		apb(1'b0, idx, 8'h00);
		chk(rdata, {24'h00_0000, exp});
	endtask

	// Times one converter clock period after the divider has settled.
	task automatic div_chk(input logic [2:0] code);
		apb(1'b1, `IDX_CLK_DIV, {5'h00, code});
		@(posedge adc_clk);
		@(posedge adc_clk);
		t0 = $time;
		@(posedge adc_clk);
		chk(32'(($time - t0) / 4), 32'(4 << code));
	endtask

	task automatic conclude;
		if (failures == 0 && checked > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	// A hang in any wait ends the run as a failure.
	always @(posedge pclk) begin
		cycles++;
		if (cycles == 20000) begin
			failures++;
			conclude();
		end
	end

	// Main sequence; reserved bits are written as zero except where a readback of them is tested.
	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
		compare_mode = 1'b0;
		result_value = 16'h0000;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		rd(`IDX_CLK_DIV, 8'h02);
		rd(`IDX_TRIG_CTRL, 8'h00);
		rd(`IDX_INT_FLAG, 8'h00);
		for (int i = 0; i < 5; i++) begin
			apb(1'b1, `IDX_REF_CTRL, 8'((i << 4) | (i & 3)));
			rd(`IDX_REF_CTRL, 8'((i << 4) | (i & 3)));
			chk(32'(reference_select), 32'(i));
			chk(32'(bandgap_enable), 32'((i >> 1) & 1));
			chk(32'(thermal_sensor_enable), 32'(i & 1));
		end
		apb(1'b1, `IDX_SAMPLE, 8'hFF);
		rd(`IDX_SAMPLE, 8'h3F);
		apb(1'b1, `IDX_TRIM_LO, 8'hA5);
		apb(1'b1, `IDX_TRIM_HI, 8'h0C);
		#1 chk(32'(trim_value), 32'h0000_0CA5);
		apb(1'b1, `IDX_BYTE_LATCH, 8'h5A);
		rd(`IDX_BYTE_LATCH, 8'h5A);
		rd(`IDX_TRIM_LO, 8'hA5);
		rd(`IDX_BYTE_LATCH, 8'h0C);
		for (int v = 0; v < 2; v++) begin
			result_value <= 16'(16'h1234 + 16'(v) * 16'h1111);
			rd(`IDX_RESULT_LO, 8'(8'h34 + v * 8'h11));
			rd(`IDX_RESULT_HI, 8'(8'h12 + v * 8'h11));
		end
		apb(1'b0, 6'h05, 8'h00);
		chk(32'(err), 32'h0000_0001);
		div_chk(3'h1);
		div_chk(3'h0);
		apb(1'b1, `IDX_SAMPLE, 8'h00);
		apb(1'b1, `IDX_TRIG_CTRL, 8'h28);
		partner.pulse(10'h020);
		#1 chk(32'(sampling), 32'h0000_0000);
		apb(1'b1, `IDX_TRIG_CTRL, 8'h29);
		partner.pulse(10'h008);
		#1 chk(32'(sampling), 32'h0000_0000);
		partner.pulse(10'h020);
		#1 chk(32'(sampling), 32'h0000_0001);
		for (n = 0; n < 100 && sampling === 1'b1; n++) @(negedge pclk);
		chk(32'(n >= 2 && n <= 3 && converting === 1'b1), 32'h0000_0001);
		for (n = 0; n < 200 && conv_done !== 1'b1; n++) @(negedge pclk);
		rd(`IDX_INT_FLAG, 8'h01);
		apb(1'b1, `IDX_INT_FLAG, 8'h00);
		rd(`IDX_INT_FLAG, 8'h01);
		apb(1'b1, `IDX_INT_FLAG, 8'h01);
		rd(`IDX_INT_FLAG, 8'h00);
		// Compare hits set the flag only in compare mode.
		for (int m = 0; m < 2; m++) begin
			compare_mode <= 1'(m);
			partner.pulse(10'h100);
			#1 chk(32'(flag), 32'(m));
		end
		partner.pulse(10'h200);
		#1 chk(32'(flag), 32'h0000_0000);
		apb(1'b1, `IDX_TRIG_CTRL, 8'h2E);
		partner.pulse(10'h020);
		#1 chk(32'({sampling, adc_clk}), 32'h0000_0002);
		chk(32'(flush_pulse), 32'h0000_0001);
		conclude();
	end
endmodule // adc_config_event_trigger_tb_top

// file: bench/event_source.sv
// Partner model of the event routing and interrupt side of the converter slice.
`timescale 1ns/10ps
module event_source (
	input wire logic pclk,
	output logic [7:0] event_in,
	output logic compare_met,
	output logic vector_ack
);
	// Lines idle low; every event is a single-cycle pulse, never a level.
	initial begin
		event_in = 8'h00;
		compare_met = 1'b0;
		vector_ack = 1'b0;
	end

	// Raises the chosen lines for one cycle, changing only just after a rising edge.
	task automatic pulse(input logic [9:0] lines);
		@(posedge pclk);
		{vector_ack, compare_met, event_in} <= lines;
		@(posedge pclk);
		{vector_ack, compare_met, event_in} <= 10'h000;
	endtask
endmodule // event_source

// file: hw/adc_cfg_defs.svh
// Offsets, field positions, reset values and timing counts of the converter control slice.
`ifndef ADC_CFG_DEFS_SVH
`define ADC_CFG_DEFS_SVH
// Register indices; the byte address on the bus is four times the index.
`define IDX_REF_CTRL 6'h02
`define IDX_TRIG_CTRL 6'h03
`define IDX_CLK_DIV 6'h04
`define IDX_INT_FLAG 6'h06
`define IDX_BYTE_LATCH 6'h07
`define IDX_SAMPLE 6'h08
`define IDX_TRIM_LO 6'h0C
`define IDX_TRIM_HI 6'h0D
`define IDX_RESULT_LO 6'h10
`define IDX_RESULT_HI 6'h11
// Field positions.
`define REF_SEL_MSB 6
`define REF_SEL_LSB 4
`define BANDGAP_BIT 1
`define THERMAL_BIT 0
`define TRIG_SEL_MSB 5
`define TRIG_SEL_LSB 3
`define TRIG_ACT_MSB 2
`define TRIG_ACT_LSB 0
`define DONE_FLAG_BIT 0
// Reset values.
`define CLK_DIV_RESET 3'h2
`define BYTE_RESET 8'h00
// Converter half clock periods spent converting after sampling ends.
`define CONV_HALVES 6'h18
`endif

// file: hw/adc_cfg_pkg.sv
// Types shared by the converter control slice.
package adc_cfg_pkg;
	typedef enum logic [2:0] {
		internal_one_volt_ref = 3'h0,
		supply_div_1p6_ref = 3'h1,
		external_ref_pin_a = 3'h2,
		external_ref_pin_d = 3'h3,
		supply_half_ref = 3'h4
	} ref_sel_t;
	typedef enum logic [2:0] {
		act_none = 3'h0,
		act_start = 3'h1,
		flush_restart_action = 3'h6
	} trig_act_t;
	typedef enum {st_idle, st_sample, st_convert} conv_state_t;
endpackage

// file: hw/adc_config_event_trigger.sv
// Converter reference, trigger, prescaler, flag, byte latch, sample time and trim registers.
//
// The APB interface to the registers was decided locally.
`timescale 1ns/10ps
`include "adc_cfg_defs.svh"
module adc_config_event_trigger (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [7:0] event_in,
	input wire logic compare_mode,
	input wire logic compare_met,
	input wire logic vector_ack,
	input wire logic [15:0] result_value,
	output adc_cfg_pkg::ref_sel_t reference_select,
	output logic bandgap_enable,
	output logic thermal_sensor_enable,
	output logic [11:0] trim_value,
	output logic conversion_done_flag,
	output logic adc_clk,
	output logic sampling,
	output logic converting,
	output logic conv_done,
	output logic flush_pulse
);
	import adc_cfg_pkg::*;

	logic [2:0] ref_sel;
	logic [2:0] trig_sel;
	logic [2:0] trig_act;
	logic [2:0] presc;
	logic [7:0] byte_latch;
	logic [5:0] sample_time_value;
	logic [8:0] div_cnt;
	logic [5:0] half_cnt;
	logic pending;
	logic err_q;
	conv_state_t state;

	// True when a word index names a register of this slice.
	function automatic logic is_mapped(input logic [5:0] i);
		is_mapped = (i == `IDX_REF_CTRL) || (i == `IDX_TRIG_CTRL) || (i == `IDX_CLK_DIV) ||
			(i == `IDX_INT_FLAG) || (i == `IDX_BYTE_LATCH) || (i == `IDX_SAMPLE) ||
			(i == `IDX_TRIM_LO) || (i == `IDX_TRIM_HI) || (i == `IDX_RESULT_LO) ||
			(i == `IDX_RESULT_HI);
	endfunction

	// Bus decode; only whole aligned words are mapped.
	wire [5:0] idx = paddr[7:2];
	wire hit = is_mapped(idx) && (paddr[1:0] == 2'h0);
	wire setup = psel & ~penable;
	wire done_xfer = psel & penable;
	wire wr = done_xfer & pwrite & ~err_q;
	wire rd = done_xfer & ~pwrite & ~err_q;
	wire [7:0] wb = pwdata[7:0];
	wire wr_ref = wr && (idx == `IDX_REF_CTRL);
	wire wr_trig = wr && (idx == `IDX_TRIG_CTRL);
	wire wr_div = wr && (idx == `IDX_CLK_DIV);
	wire wr_flag = wr && (idx == `IDX_INT_FLAG);
	wire wr_latch = wr && (idx == `IDX_BYTE_LATCH);
	wire wr_samp = wr && (idx == `IDX_SAMPLE);
	wire wr_trim_lo = wr && (idx == `IDX_TRIM_LO);
	wire wr_trim_hi = wr && (idx == `IDX_TRIM_HI);
	wire rd_trim_lo = rd && (idx == `IDX_TRIM_LO);
	wire rd_res_lo = rd && (idx == `IDX_RESULT_LO);

	// Read mux; reserved bits and unmapped words read zero.
	wire [7:0] ref_byte = {1'b0, ref_sel, 2'b00, bandgap_enable, thermal_sensor_enable};
	wire [7:0] read_byte =
		(idx == `IDX_REF_CTRL) ? ref_byte :
		(idx == `IDX_TRIG_CTRL) ? {2'b00, trig_sel, trig_act} :
		(idx == `IDX_CLK_DIV) ? {5'h00, presc} :
		(idx == `IDX_INT_FLAG) ? {7'h00, conversion_done_flag} :
		(idx == `IDX_BYTE_LATCH) ? byte_latch :
		(idx == `IDX_SAMPLE) ? {2'b00, sample_time_value} :
		(idx == `IDX_TRIM_LO) ? trim_value[7:0] :
		(idx == `IDX_RESULT_LO) ? result_value[7:0] :
		((idx == `IDX_TRIM_HI) || (idx == `IDX_RESULT_HI)) ? byte_latch :
		8'h00;

	// Zero-wait slave: data and error are captured in setup, so the access phase ends at once.
	// Read side effects such as the latch capture still wait for the access edge, so a
	// refused or abandoned setup never disturbs the latch.
	assign pready = 1'b1;
	assign pslverr = done_xfer & err_q;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
			err_q <= 1'b0;
		end else if (setup) begin
			prdata <= {24'h00_0000, (hit ? read_byte : 8'h00)};
			err_q <= ~hit;
		end
	end

	// Configuration registers; only defined fields are stored.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ref_sel <= 3'h0;
			bandgap_enable <= 1'b0;
			thermal_sensor_enable <= 1'b0;
			trig_sel <= 3'h0;
			trig_act <= 3'h0;
			presc <= `CLK_DIV_RESET;
			sample_time_value <= 6'h00;
			trim_value <= 12'h000;
		end else begin
			if (wr_ref) begin
				ref_sel <= wb[`REF_SEL_MSB:`REF_SEL_LSB];
				bandgap_enable <= wb[`BANDGAP_BIT];
				thermal_sensor_enable <= wb[`THERMAL_BIT];
			end
			if (wr_trig) begin
				trig_sel <= wb[`TRIG_SEL_MSB:`TRIG_SEL_LSB];
				trig_act <= wb[`TRIG_ACT_MSB:`TRIG_ACT_LSB];
			end
			if (wr_div)
				presc <= wb[2:0];
			if (wr_samp)
				sample_time_value <= wb[5:0];
			if (wr_trim_lo)
				trim_value[7:0] <= wb;
			if (wr_trim_hi)
				trim_value[11:8] <= wb[3:0];
		end
	end
	// Reserved reference codes pass through as stored; the analog side treats them as off.
	assign reference_select = ref_sel_t'(ref_sel);

	// Byte latch: software access, or high byte capture on a low byte read.
	// A software write would win over a capture, but both cannot fall in one transfer,
	// since a single access is either a read or a write.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			byte_latch <= `BYTE_RESET;
		else if (wr_latch)
			byte_latch <= wb;
		else if (rd_trim_lo)
			byte_latch <= {4'h0, trim_value[11:8]};
		else if (rd_res_lo)
			byte_latch <= result_value[15:8];
	end

	// Event decode; reserved action codes behave as none.
	wire trig_hit = event_in[trig_sel];
	wire start_req = (trig_act == act_start) && trig_hit;
	wire flush_req = (trig_act == flush_restart_action) && trig_hit;

	// Prescaler: a half period is div/2 clocks; flush restarts it from zero.
	// The end test is a compare of at least, not equality, so that a smaller divider written
	// while the counter stands above its new end point takes effect at once instead of
	// running the counter all the way round first.
	wire [9:0] half_len = 10'h002 << presc;
	wire [8:0] half_last = 9'(half_len - 10'h001);
	wire half_tick = (div_cnt >= half_last);
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_cnt <= 9'h000;
			adc_clk <= 1'b0;
		end else if (flush_req) begin
			div_cnt <= 9'h000;
			adc_clk <= 1'b0;
		end else if (half_tick) begin
			div_cnt <= 9'h000;
			adc_clk <= ~adc_clk;
		end else begin
			div_cnt <= 9'(div_cnt + 9'h001);
		end
	end

	// Conversion sequencer: sample, then convert, counted in converter half periods.
	// Counting starts at the prescaler phase in force when the trigger lands, so the first
	// sampling half period may be short by up to one half period less one clock.
	wire samp_end = (state == st_sample) && half_tick && (half_cnt == sample_time_value);
	wire conv_end = (state == st_convert) && half_tick &&
		(half_cnt == 6'(`CONV_HALVES - 6'h01));
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= st_idle;
			half_cnt <= 6'h00;
		end else if (flush_req) begin
			state <= st_sample;
			half_cnt <= 6'h00;
		end else begin
			unique case (state)
				st_idle: begin
					if (start_req || pending) begin
						state <= st_sample;
						half_cnt <= 6'h00;
					end
				end
				st_sample: begin
					if (samp_end) begin
						state <= st_convert;
						half_cnt <= 6'h00;
					end else if (half_tick) begin
						half_cnt <= 6'(half_cnt + 6'h01);
					end
				end
				st_convert: begin
					if (conv_end) begin
						state <= pending ? st_sample : st_idle;
						half_cnt <= 6'h00;
					end else if (half_tick) begin
						half_cnt <= 6'(half_cnt + 6'h01);
					end
				end
			endcase
		end
	end

	// A trigger that lands while busy waits; a flush leaves it waiting so it resumes after.
	// Only one trigger is remembered: further triggers while one waits merge into it.
	// Software that wants a clean flush must make sure that no trigger is waiting first.
	wire take_pending = ~flush_req & pending & ((state == st_idle) | conv_end);
	wire hold_start = start_req & (state != st_idle);
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			pending <= 1'b0;
		else if (hold_start)
			pending <= 1'b1;
		else if (take_pending)
			pending <= 1'b0;
	end

	// Status outputs and the one-cycle strobes.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			conv_done <= 1'b0;
			flush_pulse <= 1'b0;
		end else begin
			conv_done <= conv_end & ~flush_req;
			flush_pulse <= flush_req;
		end
	end
	assign sampling = (state == st_sample);
	assign converting = (state == st_convert);

	// Done flag: the set wins over both clears so no completion is lost.
	// A completion that coincides with the vector or a clearing write is thus seen again
	// by software, at the cost of one extra interrupt entry.
	wire flag_set = compare_mode ? compare_met : conv_done;
	wire flag_clr = (wr_flag & wb[`DONE_FLAG_BIT]) | vector_ack;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			conversion_done_flag <= 1'b0;
		else if (flag_set)
			conversion_done_flag <= 1'b1;
		else if (flag_clr)
			conversion_done_flag <= 1'b0;
	end

	// Checks on the behaviour above.
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	ref_field_a: assert property (wr_ref |=> ref_sel == $past(wb[6:4]))
		else $error("reference selector not taken from bits 6:4");
	flag_set_a: assert property (flag_set |=> conversion_done_flag)
		else $error("done flag failed to set");
	flag_clear_a: assert property (vector_ack && !flag_set |=> !conversion_done_flag)
		else $error("vector did not clear done flag");
	w1c_keep_a: assert property (wr_flag && !wb[0] && !vector_ack && !flag_set |=>
		conversion_done_flag == $past(conversion_done_flag))
		else $error("writing zero changed done flag");
	latch_cap_a: assert property (rd_res_lo |=> byte_latch == $past(result_value[15:8]))
		else $error("high byte not captured on low read");
	high_read_a: assert property (setup && paddr == 8'h44 |=>
		prdata[7:0] == $past(byte_latch))
		else $error("high byte read did not return latch");
	reserved_zero_a: assert property (setup && paddr == 8'h18 |=> prdata[31:1] == 31'h0)
		else $error("reserved flag bits not zero");
	none_ignores_a: assert property (trig_act == 3'h0 && state == st_idle && !pending |=>
		state == st_idle)
		else $error("event acted on with action none");
	flush_clk_a: assert property (flush_req |=>
		div_cnt == 9'h000 && !adc_clk && state == st_sample)
		else $error("flush did not restart converter");
	start_a: assert property (start_req && state == st_idle |=> state == st_sample)
		else $error("selected event did not start conversion");
	// A flush in the middle restarts the count and a divider write moves its end point, so either excuses the tick.
	div4_a: assert property (presc == 3'h0 && half_tick && !flush_req && !wr_div |=>
		!half_tick ##1 (half_tick || $past(flush_req || wr_div)))
		else $error("divide by four half period wrong");

	// Software access to the latch and the trim pair.
	latch_write_a: assert property (wr_latch |=> byte_latch == $past(wb))
		else $error("byte latch write lost");
	// The low trim byte takes all eight written bits.
	trim_low_a: assert property (wr_trim_lo |=> trim_value[7:0] == $past(wb))
		else $error("low trim byte write lost");
	// The high trim register keeps only its four defined bits.
	trim_high_a: assert property (wr_trim_hi |=> trim_value[11:8] == $past(wb[3:0]))
		else $error("high trim bits write lost");
	// A low trim read parks the high trim bits in the latch.
	trim_capture_a: assert property (rd_trim_lo |=>
		byte_latch == {4'h0, $past(trim_value[11:8])})
		else $error("trim high bits not captured on low read");
	// The high trim address answers from the latch.
	trim_read_a: assert property (setup && paddr == 8'h34 |=>
		prdata[7:0] == $past(byte_latch))
		else $error("high trim read did not return latch");
	// Reserved sample time bits read as zero.
	sample_zero_a: assert property (setup && paddr == 8'h20 |=> prdata[31:6] == 26'h0)
		else $error("reserved sample time bits not zero");
	// Refused words read as zero and raise the error.
	err_read_a: assert property (setup && !hit |=> prdata == 32'h0000_0000 && err_q)
		else $error("refused access not answered with error");

	// Configuration fields follow the written byte.
	enable_bits_a: assert property (wr_ref |=>
		bandgap_enable == $past(wb[1]) && thermal_sensor_enable == $past(wb[0]))
		else $error("bandgap or thermal enable not taken");
	// The reference selector changes only on a write to its register.
	ref_keep_a: assert property (!wr_ref |=> ref_sel == $past(ref_sel))
		else $error("reference selector changed without write");
	// Trigger channel and action come from bits 5:3 and 2:0.
	trig_field_a: assert property (wr_trig |=>
		trig_sel == $past(wb[5:3]) && trig_act == $past(wb[2:0]))
		else $error("trigger fields not taken");
	// The divider code comes from bits 2:0.
	presc_field_a: assert property (wr_div |=> presc == $past(wb[2:0]))
		else $error("prescaler code not taken");
	// Every half period end without a flush toggles the converter clock.
	adc_half_a: assert property (half_tick && !flush_req |=> adc_clk != $past(adc_clk))
		else $error("converter clock did not toggle");

	// Event actions and the sequencer.
	flush_strobe_a: assert property (flush_req |=> flush_pulse)
		else $error("flush strobe missing");
	// Reserved action codes leave an idle converter idle.
	reserved_act_a: assert property (trig_act != 3'h1 && trig_act != 3'h6 &&
		state == st_idle && !pending |=> state == st_idle)
		else $error("reserved action code acted on event");
	// Sampling goes on until the programmed half period count is reached.
	sample_hold_a: assert property (state == st_sample && half_tick &&
		half_cnt != sample_time_value |=> sampling)
		else $error("sampling ended early");
	// At the programmed count the sequencer moves on to converting.
	sample_end_a: assert property (samp_end && !flush_req |=> converting)
		else $error("sampling did not end on time");
	// The end of conversion raises the completion strobe.
	done_pulse_a: assert property (conv_end && !flush_req |=> conv_done)
		else $error("completion strobe missing");
	// Without a set or a clear the flag holds its value.
	flag_hold_a: assert property (!flag_set && !flag_clr |=>
		conversion_done_flag == $past(conversion_done_flag))
		else $error("done flag changed by itself");
	// A trigger on a busy converter is remembered.
	start_busy_a: assert property (start_req && state != st_idle |=> pending)
		else $error("trigger while busy was lost");
	// A flush keeps a waiting trigger.
	pend_keep_a: assert property (flush_req && pending |=> pending)
		else $error("flush dropped waiting trigger");

	conv_cov: cover property (state == st_convert ##1 conv_done);
	flush_cov: cover property (flush_req && state == st_convert);
	pend_cov: cover property (hold_start ##[1:300] take_pending);
	latch_cov: cover property (rd_trim_lo ##[1:4] (rd && idx == `IDX_TRIM_HI));
	start_cov: cover property (start_req && state == st_idle);
endmodule // adc_config_event_trigger
